//--- core/fsprw_pkg.sv
// Package of constants and types for the flash self-programming sequencer.
package fsprw_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] ADDR_CTRL_STATUS = 12'h000;
  localparam logic [11:0] ADDR_TARGET      = 12'h004;
  localparam logic [11:0] ADDR_CONFIG      = 12'h008;
  localparam logic [11:0] ADDR_STATE       = 12'h00c;

  // ****************************************
  // Control and status field positions
  // ****************************************
  localparam int BIT_ENABLE      = 0;
  localparam int BIT_PAGE_ERASE  = 1;
  localparam int BIT_PAGE_WRITE  = 2;
  localparam int BIT_RW_REENABLE = 4;
  localparam int BIT_RW_BUSY     = 6;
  localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;

  // ****************************************
  // Configuration field positions
  // ****************************************
  localparam int CFG_BOOT_SIZE_LSB = 0;
  localparam int CFG_APP_LOCK_LSB  = 2;
  localparam int CFG_BOOT_LOCK_LSB = 4;
  localparam logic [5:0] CONFIG_RESET = 6'h3f;

  // ****************************************
  // Flash geometry
  // ****************************************
  localparam int                FLASH_AW          = 15;
  localparam int                PAGE_AW           = 7;
  localparam logic [FLASH_AW-1:0] RWW_LIMIT       = 15'h7000;
  localparam logic [FLASH_AW-1:0] BOOT_START_0    = 15'h7000;
  localparam logic [FLASH_AW-1:0] BOOT_START_1    = 15'h7800;
  localparam logic [FLASH_AW-1:0] BOOT_START_2    = 15'h7c00;
  localparam logic [FLASH_AW-1:0] BOOT_START_3    = 15'h7e00;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS  = 5;
  localparam int PROG_TIME_US   = 4;
  localparam int PROG_CYCLES    = (PROG_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int CNT_W          = 12;

  typedef enum logic [1:0] {
    FSPRW_IDLE,
    FSPRW_RWW_PROG,
    FSPRW_NO_READ_WHILE_WRITE_AREA_PROG
  } fsprw_state_e;

endpackage

//--- core/fsprw_timer.sv
// Program-time counter for one page erase or page write.
`timescale 1ns/1ps
module fsprw_timer
  import fsprw_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // Control
  input  wire logic start,
  output logic      done
);

  logic [CNT_W-1:0] count;
  logic             running;

  // ****************************************
  // Down counter
  // ****************************************
  // Counts the program time and pulses done on the last cycle.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count   <= '0;
      running <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count   <= CNT_W'(PROG_CYCLES - 1);
        running <= 1'b1;
      end else if (running) begin
        if (count == '0) begin
          running <= 1'b0;
          done    <= 1'b1;
        end else begin
          count <= count - 1'b1;
        end
      end
    end
  end

endmodule

//--- core/fsprw_top.sv
// Flash self-programming sequencer with read-while-write control and APB registers.
// Function
// - A store-program instruction starts programming only when it executes from the boot loader section.
// - From the boot loader section a store-program may target any flash address, boot section included.
// - Programming a read-while-write page keeps the CPU running and no-read-while-write reads served.
// - Programming a no-read-while-write page halts the CPU and blocks all flash reads throughout.
// - The read-while-write area is blocked for reading whenever the busy flag reads one, and also during no-read-while-write programming.
// - The boot loader section always lies inside the no-read-while-write area for every size choice.
// - Application section protection comes from the application lock pair alone.
// - Boot section protection comes from the boot section lock pair alone.
// - Boot size fuses set the section split; the read-while-write boundary is fixed.
// - Page organisation applies only to programming, never to fetch or program-memory reads.
// - The busy flag is read-only bit 6 of the control and status register and resets to zero.
// - With the application lock pair unprogrammed there is no restriction; lower bit alone forbids writes.
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
module fsprw_top
  import fsprw_pkg::*;
(
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst_b,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // CPU side
  input  wire logic                store_program_instr,
  input  wire logic [FLASH_AW-1:0] pc_addr,
  input  wire logic [FLASH_AW-1:0] fetch_addr,
  output logic                     cpu_halt,
  output logic                     rww_read_block,
  output logic                     no_read_while_write_area_read_block,
  // Flash array
  output logic                     flash_erase,
  output logic                     flash_write,
  output logic      [FLASH_AW-1:0] flash_page_addr,
  output logic                     rw_area_busy_flag
);

  // ****************************************
  // Declarations
  // ****************************************
  fsprw_state_e        state;
  fsprw_state_e        next_state;
  logic                ctrl_enable;
  logic                ctrl_erase;
  logic                ctrl_write;
  logic [FLASH_AW-1:0] target;
  logic [1:0]          boot_size_fuses;
  logic [1:0]          application_lock_pair;
  logic [1:0]          boot_section_lock_pair;
  logic                timer_done;

  // Boot section start selected by the size fuses.
  function automatic logic [FLASH_AW-1:0] boot_start(input logic [1:0] sz);
    unique case (sz)
      2'h0:    boot_start = BOOT_START_0;
      2'h1:    boot_start = BOOT_START_1;
      2'h2:    boot_start = BOOT_START_2;
      default: boot_start = BOOT_START_3;
    endcase
  endfunction

  // Whether a lock pair forbids store-program writes (lower bit programmed).
  function automatic logic write_locked(input logic [1:0] pair);
    write_locked = ~pair[0];
  endfunction

  // ****************************************
  // Decode
  // ****************************************
  // The area split is fixed, while the boot section moves with the size fuses.
  // Every size choice keeps the boot section above the fixed limit.
  // Section split and lock checks for a store-program request.
  wire [FLASH_AW-1:0] boot_base    = boot_start(boot_size_fuses);
  wire                pc_in_boot   = (pc_addr >= boot_base);
  wire                tgt_in_boot  = (target >= boot_base);
  wire                tgt_in_rww   = (target < RWW_LIMIT);
  wire                lock_app     = write_locked(application_lock_pair);
  wire                lock_boot    = write_locked(boot_section_lock_pair);
  wire                tgt_locked   = tgt_in_boot ? lock_boot : lock_app;
  wire                prog_op      = ctrl_enable & (ctrl_erase | ctrl_write);
  wire                spm_ok       = store_program_instr & prog_op & pc_in_boot & ~tgt_locked;
  wire                fetch_in_rww = (fetch_addr < RWW_LIMIT);
  wire                apb_write    = psel & penable & pwrite;
  wire                wr_ctrl      = apb_write & (paddr == ADDR_CTRL_STATUS);
  wire                wr_target    = apb_write & (paddr == ADDR_TARGET);
  wire                wr_config    = apb_write & (paddr == ADDR_CONFIG);
  wire                rw_reenable  = wr_ctrl & pwdata[BIT_RW_REENABLE];
  wire                known_addr   = (paddr == ADDR_CTRL_STATUS) | (paddr == ADDR_TARGET) |
                                     (paddr == ADDR_CONFIG) | (paddr == ADDR_STATE);
  wire                rww_start    = spm_ok & tgt_in_rww & (state == FSPRW_IDLE);
  wire                no_read_while_write_area_start   = spm_ok & ~tgt_in_rww & (state == FSPRW_IDLE);
  wire                prog_launch  = rww_start | no_read_while_write_area_start;
  // Set wins over a clear in the same cycle, so a fresh start is never lost.
  wire                next_busy    = rww_start | (rw_area_busy_flag & ~(rw_reenable & (state != FSPRW_RWW_PROG)));

  // Read mux of the register file.
  // Bit 6 comes from the flag alone, so software cannot set it by writing it.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      ADDR_CTRL_STATUS: begin
        rd_mux[BIT_ENABLE]     = ctrl_enable;
        rd_mux[BIT_PAGE_ERASE] = ctrl_erase;
        rd_mux[BIT_PAGE_WRITE] = ctrl_write;
        rd_mux[BIT_RW_BUSY]    = rw_area_busy_flag;
      end
      ADDR_TARGET: rd_mux[FLASH_AW-1:0] = target;
      ADDR_CONFIG: rd_mux[5:0] = {boot_section_lock_pair, application_lock_pair, boot_size_fuses};
      ADDR_STATE:  rd_mux[1:0] = state;
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // Next state: read-while-write keeps the CPU live, the other area halts it.
  // A start is taken only in idle, so a store-program during programming is ignored.
  always_comb begin
    next_state = state;
    unique case (state)
      FSPRW_IDLE: begin
        if (rww_start) begin
          next_state = FSPRW_RWW_PROG;
        end else if (no_read_while_write_area_start) begin
          next_state = FSPRW_NO_READ_WHILE_WRITE_AREA_PROG;
        end
      end
      FSPRW_RWW_PROG: begin
        if (timer_done) begin
          next_state = FSPRW_IDLE;
        end
      end
      FSPRW_NO_READ_WHILE_WRITE_AREA_PROG: begin
        if (timer_done) begin
          next_state = FSPRW_IDLE;
        end
      end
      default: next_state = FSPRW_IDLE;
    endcase
  end

  // Page-time counter; page boundaries matter only to the flash page address below.
  // Erase and write share one program time.
  fsprw_timer u_timer (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .start   (rww_start | no_read_while_write_area_start),
    .done    (timer_done)
  );

  // State register.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= FSPRW_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Flash strobes and page address; only programming uses the page grid.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      flash_erase     <= 1'b0;
      flash_write     <= 1'b0;
      flash_page_addr <= '0;
    end else begin
      flash_erase <= (rww_start | no_read_while_write_area_start) & ctrl_erase;
      flash_write <= (rww_start | no_read_while_write_area_start) & ~ctrl_erase & ctrl_write;
      if (rww_start | no_read_while_write_area_start) begin
        flash_page_addr <= {target[FLASH_AW-1:PAGE_AW], {PAGE_AW{1'b0}}};
      end
    end
  end

  // CPU halt and read blocking outputs.
  // They are taken from next_state so that they move on the same edge as the state.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_halt        <= 1'b0;
      rww_read_block  <= 1'b0;
      no_read_while_write_area_read_block <= 1'b0;
    end else begin
      cpu_halt        <= (next_state == FSPRW_NO_READ_WHILE_WRITE_AREA_PROG);
      no_read_while_write_area_read_block <= (next_state == FSPRW_NO_READ_WHILE_WRITE_AREA_PROG);
      rww_read_block  <= (next_state != FSPRW_IDLE) | next_busy;
    end
  end

  // Busy flag: set on a read-while-write start, held until software re-enables.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rw_area_busy_flag <= 1'b0;
    end else begin
      rw_area_busy_flag <= next_busy;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Control bits clear themselves when an operation is launched.
  // This stops a held store-program from starting a second operation.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_enable <= CTRL_STATUS_RESET[BIT_ENABLE];
      ctrl_erase  <= CTRL_STATUS_RESET[BIT_PAGE_ERASE];
      ctrl_write  <= CTRL_STATUS_RESET[BIT_PAGE_WRITE];
    end else if (rww_start | no_read_while_write_area_start) begin
      ctrl_enable <= 1'b0;
      ctrl_erase  <= 1'b0;
      ctrl_write  <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_enable <= pwdata[BIT_ENABLE];
      ctrl_erase  <= pwdata[BIT_PAGE_ERASE];
      ctrl_write  <= pwdata[BIT_PAGE_WRITE];
    end
  end

  // Target address and configuration copies.
  // Writes while programming are dropped so the page and the split cannot move.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      target                 <= '0;
      boot_size_fuses        <= CONFIG_RESET[CFG_BOOT_SIZE_LSB +: 2];
      application_lock_pair  <= CONFIG_RESET[CFG_APP_LOCK_LSB +: 2];
      boot_section_lock_pair <= CONFIG_RESET[CFG_BOOT_LOCK_LSB +: 2];
    end else begin
      if (wr_target && state == FSPRW_IDLE) begin
        target <= pwdata[FLASH_AW-1:0];
      end
      if (wr_config && state == FSPRW_IDLE) begin
        boot_size_fuses        <= pwdata[CFG_BOOT_SIZE_LSB +: 2];
        application_lock_pair  <= pwdata[CFG_APP_LOCK_LSB +: 2];
        boot_section_lock_pair <= pwdata[CFG_BOOT_LOCK_LSB +: 2];
      end
    end
  end

  // APB answer: no wait state, error on unmapped address.
  // Read data and the error flag stand only while pready is high.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~known_addr;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  // Placement, start rules, blocking and the busy flag.
  a_boot_in_no_read_while_write_area: assert property (@(posedge sys_clk) disable iff (!rst_b)
    boot_base >= RWW_LIMIT) else $error("Boot section overlaps the read-while-write area.");
  a_app_no_start: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state == FSPRW_IDLE && !pc_in_boot) |=> state == FSPRW_IDLE) else $error("Start from application code.");
  a_rww_no_halt: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rww_start |=> !cpu_halt && rww_read_block && !no_read_while_write_area_read_block) else $error("Wrong blocking for rww.");
  a_no_read_while_write_area_halts: assert property (@(posedge sys_clk) disable iff (!rst_b)
    no_read_while_write_area_start |=> cpu_halt && no_read_while_write_area_read_block && rww_read_block) else $error("No halt for no_read_while_write_area program.");
  a_busy_sets: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rww_start |=> rw_area_busy_flag) else $error("Busy flag did not set.");
  a_busy_holds: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (rw_area_busy_flag && !rw_reenable) |=> rw_area_busy_flag) else $error("Busy flag dropped early.");
  a_app_lock: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (application_lock_pair[0] == 1'b0 && !tgt_in_boot) |-> !spm_ok) else $error("Write to locked app.");
  a_boot_lock: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (boot_section_lock_pair[0] == 1'b0 && tgt_in_boot) |-> !spm_ok) else $error("Write to locked boot.");
  a_page_align: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (flash_erase || flash_write) |-> flash_page_addr[PAGE_AW-1:0] == '0) else $error("Unaligned page.");
  a_busy_blocks: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rw_area_busy_flag |-> rww_read_block)
    else $error("Busy flag set but area readable.");
  a_no_read_while_write_area_served: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state == FSPRW_RWW_PROG && !fetch_in_rww) |-> !no_read_while_write_area_read_block && !cpu_halt)
    else $error("Fixed-area fetch not served.");

  // Halt and read blocking follow the sequencer state and the busy flag.
  a_halt_no_read_while_write_area: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cpu_halt == (state == FSPRW_NO_READ_WHILE_WRITE_AREA_PROG))
    else $error("Halt does not match the state.");
  a_halt_blocks: assert property (@(posedge sys_clk) disable iff (!rst_b)
    no_read_while_write_area_read_block == cpu_halt)
    else $error("Fixed-area block differs from halt.");
  a_halt_all_blocked: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cpu_halt |-> rww_read_block && no_read_while_write_area_read_block)
    else $error("Flash readable during a halt.");
  a_block_tracks: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rww_read_block == (state != FSPRW_IDLE || rw_area_busy_flag))
    else $error("Area block does not track programming.");
  a_rww_prog_busy: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state == FSPRW_RWW_PROG) |-> rw_area_busy_flag)
    else $error("Busy flag low during programming.");

  // The flag sets only on a start and clears in any state but read-while-write programming.
  a_busy_ro: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!rw_area_busy_flag && !rww_start) |=> !rw_area_busy_flag)
    else $error("Busy flag set without a start.");
  a_busy_clears: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (rw_reenable && state == FSPRW_IDLE && !rww_start) |=> !rw_area_busy_flag)
    else $error("Busy flag not cleared.");

  // Strobes come only from a launch, one kind at a time.
  a_strobe_launch: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (flash_erase || flash_write) |-> $past(prog_launch))
    else $error("Strobe without a launch.");
  a_one_strobe: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !(flash_erase && flash_write))
    else $error("Erase and write together.");
  a_target_frozen: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state != FSPRW_IDLE) |=> $stable(target))
    else $error("Target moved during programming.");

  // Section protection and the fuse split.
  a_app_free: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (application_lock_pair == 2'h3 && !tgt_in_boot && store_program_instr && prog_op && pc_in_boot
     && state == FSPRW_IDLE) |=> state != FSPRW_IDLE)
    else $error("Unlocked application write refused.");
  a_app_indep: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (application_lock_pair[0] && !tgt_in_boot) |-> !tgt_locked)
    else $error("Application lock taken from the wrong pair.");
  a_boot_indep: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (boot_section_lock_pair[0] && tgt_in_boot) |-> !tgt_locked)
    else $error("Boot lock taken from the wrong pair.");
  a_fuses_frozen: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state != FSPRW_IDLE) |=> $stable(boot_size_fuses))
    else $error("Section split changed during programming.");

endmodule

//--- verif/fsprw_cpu_model.sv
// Behavioural model of the CPU core that runs the boot loader software.
`timescale 1ns/1ps
module fsprw_cpu_model
  import fsprw_pkg::*;
(
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst_b,
  // Bench commands
  input  wire logic                spm_req,
  input  wire logic [FLASH_AW-1:0] spm_pc,
  // Sequencer status
  input  wire logic                cpu_halt,
  input  wire logic                rww_read_block,
  // Core outputs
  output logic                     store_program_instr,
  output logic      [FLASH_AW-1:0] pc_addr,
  output logic      [FLASH_AW-1:0] fetch_addr
);
  // One store-program instruction per request; a halted core executes nothing.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      store_program_instr <= 1'b0;
      pc_addr             <= 15'h0000;
    end else begin
      store_program_instr <= spm_req & ~cpu_halt;
      if (spm_req) begin
        pc_addr <= spm_pc;
      end
    end
  end

  // Fetches move into the fixed area one cycle after the other one is blocked and stay there while the block lasts.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fetch_addr <= 15'h0000;
    end else if (!cpu_halt) begin
      fetch_addr <= (fetch_addr + 15'h0001) | (rww_read_block ? RWW_LIMIT : 15'h0000);
    end
  end
endmodule

//--- verif/fsprw_top_tb.sv
// Self-checking bench for the flash self-programming sequencer.
`timescale 1ns/1ps
module fsprw_top_tb
  import fsprw_pkg::*;
;
  logic                sys_clk = 1'b0;
  logic                rst_b   = 1'b0;
  logic                psel    = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite  = 1'b0;
  logic [11:0]         paddr   = 12'h000;
  logic [31:0]         pwdata  = 32'h0;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                spm_req = 1'b0;
  logic [FLASH_AW-1:0] spm_pc  = 15'h0000;
  logic                store_program_instr;
  logic [FLASH_AW-1:0] pc_addr;
  logic [FLASH_AW-1:0] fetch_addr;
  logic                cpu_halt;
  logic                rww_read_block;
  logic                no_read_while_write_area_read_block;
  logic                flash_erase;
  logic                flash_write;
  logic [FLASH_AW-1:0] flash_page_addr;
  logic                rw_area_busy_flag;
  logic [31:0]         rd;
  logic                err;
  int                  n_fail = 0;
  int                  samples_checked = 0;
  int                  n_erase = 0;
  int                  n_write = 0;

  // The clock toggles every half period.
  always #(CLK_PERIOD_NS / 2.0) sys_clk = ~sys_clk;

  fsprw_top fsprw_top_i (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .store_program_instr(store_program_instr), .pc_addr(pc_addr), .fetch_addr(fetch_addr),
    .cpu_halt(cpu_halt), .rww_read_block(rww_read_block), .no_read_while_write_area_read_block(no_read_while_write_area_read_block),
    .flash_erase(flash_erase), .flash_write(flash_write), .flash_page_addr(flash_page_addr),
    .rw_area_busy_flag(rw_area_busy_flag));

  fsprw_cpu_model fsprw_cpu_model_i (.sys_clk(sys_clk), .rst_b(rst_b), .spm_req(spm_req), .spm_pc(spm_pc),
    .cpu_halt(cpu_halt), .rww_read_block(rww_read_block), .store_program_instr(store_program_instr),
    .pc_addr(pc_addr), .fetch_addr(fetch_addr));

  // Strobes to the flash array are counted as they are sampled.
  always @(posedge sys_clk) begin
    if (flash_erase === 1'b1) n_erase++;
    if (flash_write === 1'b1) n_write++;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Arms a page operation, lets the core execute it, then counts the strobes.
  task automatic prog(input logic [14:0] tgt, input logic [7:0] op, input logic [14:0] pc, input int e, input int w);
    n_erase = 0;
    n_write = 0;
    apb(1'b1, ADDR_TARGET, {17'h0, tgt});
    apb(1'b1, ADDR_CTRL_STATUS, {24'h0, op});
    @(posedge sys_clk);
    spm_req <= 1'b1;
    spm_pc  <= pc;
    @(posedge sys_clk);
    spm_req <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("erase strobes", e, n_erase);
    chk("write strobes", w, n_write);
  endtask

  // Polls the state register until the sequencer is idle again.
  task automatic wait_idle;
    do apb(1'b0, ADDR_STATE, 32'h0); while (rd[1:0] !== FSPRW_IDLE);
    chk("state idle", {30'h0, FSPRW_IDLE}, rd);
  endtask

  // Clears the busy flag and checks that the area is readable again.
  task automatic clear_busy;
    apb(1'b1, ADDR_CTRL_STATUS, 32'h10);
    repeat (2) @(posedge sys_clk);
    chk("busy cleared", 32'h0, {31'h0, rw_area_busy_flag});
    chk("area unblocked", 32'h0, {31'h0, rww_read_block});
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    apb(1'b0, ADDR_CTRL_STATUS, 32'h0);
    chk("ctrl reset", {24'h0, CTRL_STATUS_RESET}, rd);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    chk("config reset", {26'h0, CONFIG_RESET}, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, ADDR_CTRL_STATUS, 32'h40);
    apb(1'b0, ADDR_CTRL_STATUS, 32'h0);
    chk("busy bit read only", 32'h0, {31'h0, rd[BIT_RW_BUSY]});
  endtask

  task automatic t_app_exec;
    prog(15'h1000, 8'h03, 15'h7100, 0, 0);
    chk("no block", 32'h0, {31'h0, rww_read_block});
  endtask

  task automatic t_rww;
    prog(15'h1045, 8'h03, 15'h7f00, 1, 0);
    chk("page address", {17'h0, 15'h1000}, {17'h0, flash_page_addr});
    chk("cpu runs", 32'h0, {31'h0, cpu_halt});
    chk("fixed area served", 32'h0, {31'h0, no_read_while_write_area_read_block});
    chk("area blocked", 32'h1, {31'h0, rww_read_block});
    apb(1'b0, ADDR_CTRL_STATUS, 32'h0);
    chk("busy bit set", 32'h1, {31'h0, rd[BIT_RW_BUSY]});
    wait_idle();
    chk("busy held", 32'h1, {31'h0, rw_area_busy_flag});
    chk("block held", 32'h1, {31'h0, rww_read_block});
    clear_busy();
  endtask

  task automatic t_no_read_while_write_area;
    prog(15'h7e80, 8'h05, 15'h7f00, 0, 1);
    chk("page address", {17'h0, 15'h7e80}, {17'h0, flash_page_addr});
    repeat (700) @(posedge sys_clk);
    chk("cpu halted", 32'h1, {31'h0, cpu_halt});
    chk("fixed area blocked", 32'h1, {31'h0, no_read_while_write_area_read_block});
    chk("other area blocked", 32'h1, {31'h0, rww_read_block});
    wait_idle();
    chk("cpu resumes", 32'h0, {31'h0, cpu_halt});
  endtask

  task automatic t_fuses;
    apb(1'b1, ADDR_CONFIG, 32'h3c);
    prog(15'h1000, 8'h03, 15'h7100, 1, 0);
    chk("cpu runs", 32'h0, {31'h0, cpu_halt});
    wait_idle();
    clear_busy();
  endtask

  task automatic t_locks;
    apb(1'b1, ADDR_CONFIG, 32'h3b);
    prog(15'h1000, 8'h05, 15'h7f00, 0, 0);
    prog(15'h7e80, 8'h05, 15'h7f00, 0, 1);
    wait_idle();
    apb(1'b1, ADDR_CONFIG, 32'h2f);
    prog(15'h7e80, 8'h05, 15'h7f00, 0, 0);
    prog(15'h1000, 8'h03, 15'h7f00, 1, 0);
    wait_idle();
    clear_busy();
  endtask

  // ****************************************
  // Verdict and sequencing
  // ****************************************
  task automatic report_and_stop;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Reset, then every scenario in turn.
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    t_app_exec();
    t_rww();
    t_no_read_while_write_area();
    t_fuses();
    t_locks();
    report_and_stop();
  end

  // The run needs about 4100 cycles; a hang is cut off well beyond that.
  initial begin
    repeat (40000) @(posedge sys_clk);
    n_fail++;
    report_and_stop();
  end
endmodule
